// ---- design/iopad_decoder.sv ----
`timescale 1ns/1ps
`include "iopad_defs.svh"
module iopad_decoder (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // jumper settings
   input wire logic [2:0] row_group_jumper,
   input wire logic [1:0] column_group_jumper,
   // processor address and bus control, controls all active low
   input wire logic [7:0] addr,
   input wire logic io_req_b,
   input wire logic io_exp_b,
   input wire logic rd_b,
   input wire logic wr_b,
   // processor data bus, split pin
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // card data toward counter and ports
   input wire logic [7:0] card_rd_data,
   output logic [7:0] card_wr_data,
   // counter device interface
   output logic counter_cs_b,
   output logic [1:0] counter_reg,
   output logic counter_rd_b,
   output logic counter_wr_b,
   // upper port strobes
   output logic [3:0] upper_port_read_strobe_b,
   output logic [3:0] upper_port_write_strobe_b,
   // card select status
   output logic card_sel
);
   logic row_hit;
   logic col_hit;
   logic [7:0] row_line;
   logic [3:0] col_line;
   logic access;
   logic sel;
   logic lower;
   logic upper;
   logic [1:0] port_idx;
   iopad_pkg::iopad_state_t state_reg;
   iopad_pkg::iopad_state_t state_next;

   // row decoder outputs x0..x7, one per value of a7..a5
   // each line is one output of the first-level decoder
   iopad_group_match #(.W(3)) u_row0 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h0),
      .hit(row_line[0])
   );

   iopad_group_match #(.W(3)) u_row1 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h1),
      .hit(row_line[1])
   );

   iopad_group_match #(.W(3)) u_row2 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h2),
      .hit(row_line[2])
   );

   iopad_group_match #(.W(3)) u_row3 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h3),
      .hit(row_line[3])
   );

   iopad_group_match #(.W(3)) u_row4 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h4),
      .hit(row_line[4])
   );

   iopad_group_match #(.W(3)) u_row5 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h5),
      .hit(row_line[5])
   );

   iopad_group_match #(.W(3)) u_row6 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h6),
      .hit(row_line[6])
   );

   iopad_group_match #(.W(3)) u_row7 (
      .field(addr[`IOPAD_ROW_HI:`IOPAD_ROW_LO]),
      .jumper(3'h7),
      .hit(row_line[7])
   );

   // column decoder outputs y0..y3, one per value of a4..a3
   iopad_group_match #(.W(2)) u_col0 (
      .field(addr[`IOPAD_COL_HI:`IOPAD_COL_LO]),
      .jumper(2'h0),
      .hit(col_line[0])
   );

   iopad_group_match #(.W(2)) u_col1 (
      .field(addr[`IOPAD_COL_HI:`IOPAD_COL_LO]),
      .jumper(2'h1),
      .hit(col_line[1])
   );

   iopad_group_match #(.W(2)) u_col2 (
      .field(addr[`IOPAD_COL_HI:`IOPAD_COL_LO]),
      .jumper(2'h2),
      .hit(col_line[2])
   );

   iopad_group_match #(.W(2)) u_col3 (
      .field(addr[`IOPAD_COL_HI:`IOPAD_COL_LO]),
      .jumper(2'h3),
      .hit(col_line[3])
   );

   // jumper matrix: exactly one strap per group picks the decoder line;
   // the card ships strapped at row 6, column 3, block d8..df
   assign row_hit = row_line[row_group_jumper];
   assign col_hit = col_line[column_group_jumper];

   // card select: a7..a3 fixed, a2..a0 free so eight ports, base x0 or x8
   assign access = !io_req_b && !io_exp_b && (!rd_b || !wr_b);
   assign sel = access && row_hit && col_hit;
   // a2 splits the block: low half counter, high half strobes
   assign lower = sel && !addr[`IOPAD_SPLIT_BIT];
   assign upper = sel && addr[`IOPAD_SPLIT_BIT];

   // low address bits name the port inside each half
   assign port_idx = addr[`IOPAD_REG_HI:`IOPAD_REG_LO];
   assign card_sel = sel;

   // counter device side, combinational within the bus cycle
   assign counter_cs_b = !lower;
   assign counter_reg = addr[`IOPAD_REG_HI:`IOPAD_REG_LO];
   assign counter_rd_b = rd_b;
   assign counter_wr_b = wr_b;

   // data buffer direction
   assign data_oe = sel && !rd_b;
   assign data_out = card_rd_data;
   assign card_wr_data = data_in;

   // upper strobes decoded live for the cycle, registered copy tracks route
   always_comb begin
      logic [3:0] port_line_b;
      port_line_b = `IOPAD_STROBE_IDLE;
      state_next = state_reg;
      state_next.rd_strobe_b = 4'hf;
      state_next.wr_strobe_b = 4'hf;
      // route follows the half addressed in this cycle
      if (upper) begin
         state_next.route = iopad_pkg::IOPAD_UPPER;
      end else if (lower) begin
         state_next.route = iopad_pkg::IOPAD_LOWER;
      end else begin
         state_next.route = iopad_pkg::IOPAD_IDLE;
      end
      case (state_next.route)
         iopad_pkg::IOPAD_UPPER: begin
            // second-level decoder: one low line per upper port
            case (port_idx)
               2'h0: begin
                  port_line_b = 4'he;
               end
               2'h1: begin
                  port_line_b = 4'hd;
               end
               2'h2: begin
                  port_line_b = 4'hb;
               end
               2'h3: begin
                  port_line_b = 4'h7;
               end
               default: begin
                  port_line_b = `IOPAD_STROBE_IDLE;
               end
            endcase
            // read and write gate the same line onto separate strobes
            if (!rd_b) begin
               state_next.rd_strobe_b = port_line_b;
            end
            if (!wr_b) begin
               state_next.wr_strobe_b = port_line_b;
            end
         end
         iopad_pkg::IOPAD_LOWER: begin
         end
         iopad_pkg::IOPAD_IDLE: begin
         end
         default: begin
            state_next.route = iopad_pkg::IOPAD_IDLE;
         end
      endcase
      // reset holds every upper port strobe inactive
      if (!rst_b) begin
         state_next.route = iopad_pkg::IOPAD_IDLE;
         state_next.rd_strobe_b = 4'hf;
         state_next.wr_strobe_b = 4'hf;
      end
   end

   // registered route copy; strobes never wait on it, no cycle lost
   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   // strobes are handshake outputs: live so the port acts in the same cycle
   assign upper_port_read_strobe_b = state_next.rd_strobe_b;
   assign upper_port_write_strobe_b = state_next.wr_strobe_b;
endmodule : iopad_decoder

// ---- design/iopad_defs.svh ----
`ifndef IOPAD_DEFS_SVH
`define IOPAD_DEFS_SVH
// default jumper positions: row group 6, column group 3 -> block d8..df
`define IOPAD_ROW_DEFAULT 3'h6
`define IOPAD_COL_DEFAULT 2'h3
// address field positions
`define IOPAD_ROW_HI 7
`define IOPAD_ROW_LO 5
`define IOPAD_COL_HI 4
`define IOPAD_COL_LO 3
`define IOPAD_SPLIT_BIT 2
`define IOPAD_REG_HI 1
`define IOPAD_REG_LO 0
// number of ports in the block and in each half
`define IOPAD_BLOCK_PORTS 8
`define IOPAD_HALF_PORTS 4
// idle level of the active-low strobe groups
`define IOPAD_STROBE_IDLE 4'hf
`endif

// ---- design/iopad_group_match.sv ----
`timescale 1ns/1ps
// one-hot jumper group decoder: selects one output of a group
module iopad_group_match #(
   parameter int W = 3
) (
   // address field and jumper choice
   input wire logic [W-1:0] field,
   input wire logic [W-1:0] jumper,
   // match
   output logic hit
);
   // jumper picks which decoder output is wired to the card select
   always_comb begin
      hit = (field == jumper);
   end
endmodule : iopad_group_match

// ---- design/iopad_pkg.sv ----
package iopad_pkg;
   // which half of the block an access targets
   typedef enum logic [2:0] {
      IOPAD_IDLE = 3'b001,
      IOPAD_LOWER = 3'b010,
      IOPAD_UPPER = 3'b100
   } iopad_route_t;

   // registered strobe state
   typedef struct packed {
      iopad_route_t route;
      logic [3:0] rd_strobe_b;
      logic [3:0] wr_strobe_b;
   } iopad_state_t;
endpackage : iopad_pkg

// ---- tb/iopad_cpu.sv ----
`timescale 1ns/1ps
module iopad_cpu (
   // bus toward the card
   input wire logic clk,
   output logic [7:0] addr = 8'h00,
   output logic [3:0] ctl = 4'hf,
   output logic [7:0] dq = 8'h00
);
   // one bus cycle, then release; a released data bus toggles
   task automatic cycle(logic [7:0] a, logic [3:0] c, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      ctl <= c;
      dq <= c[0] ? ~dq : d;
      @(posedge clk);
      ctl <= 4'hf;
      dq <= ~d;
   endtask : cycle
endmodule : iopad_cpu

// ---- tb/iopad_decoder_properties.sv ----
`timescale 1ns/1ps
module iopad_chk (
   // watched ports
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic io_req_b,
   input wire logic io_exp_b,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic data_oe,
   input wire logic counter_cs_b,
   input wire logic [3:0] upper_port_read_strobe_b,
   input wire logic [3:0] upper_port_write_strobe_b,
   input wire logic card_sel
);
   // upper half access and end of a read
   wire logic up = card_sel && addr[2];
   sequence s_rd;
      up && !rd_b ##1 rd_b && wr_b;
   endsequence
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_SEL: assert property (card_sel |-> !io_req_b && !io_exp_b &&
      !(rd_b && wr_b)) else $error("sel");
   AST_OFF: assert property ($rose(io_exp_b) |-> !card_sel)
      else $error("off");
   AST_OE: assert property (data_oe == (card_sel && !rd_b))
      else $error("oe");
   AST_CNT: assert property (counter_cs_b == !(card_sel && !addr[2]))
      else $error("cnt");
   AST_ONE: assert property (!counter_cs_b |->
      &upper_port_read_strobe_b && &upper_port_write_strobe_b)
      else $error("one");
   AST_RD: assert property (upper_port_read_strobe_b ==
      ~(4'(up && !rd_b) << addr[1:0])) else $error("rd");
   AST_WR: assert property (upper_port_write_strobe_b ==
      ~(4'(up && !wr_b) << addr[1:0])) else $error("wr");
   AST_END: assert property (s_rd |-> !data_oe && &upper_port_read_strobe_b)
      else $error("end");
endmodule : iopad_chk
bind iopad_decoder iopad_chk u_chk (.*);

// ---- tb/test_iopad_decoder.sv ----
`timescale 1ns/1ps
module test_iopad_decoder;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr, din, dout, wdat, rdat = 8'h00;
   logic [3:0] ctl, rs, ws;
   logic [2:0] row = 3'h6;
   logic [1:0] creg, col = 2'h3;
   logic oe, cs, crd, cwr, sel;
   int err_count = 0, n_tests = 0, seed = 32'ha92b0b7f, hit, up;
   logic [3:0] bad [4] = '{4'h9, 4'h5, 4'h3, 4'h0};
   // clock and instances
   always #20 clk = ~clk;
   iopad_cpu u_cpu (.clk, .addr, .ctl, .dq(din));
   iopad_decoder u_dut (.clk, .rst_b, .row_group_jumper(row),
      .column_group_jumper(col), .addr, .io_req_b(ctl[3]),
      .io_exp_b(ctl[2]), .rd_b(ctl[1]), .wr_b(ctl[0]), .data_in(din),
      .data_out(dout), .data_oe(oe), .card_rd_data(rdat),
      .card_wr_data(wdat), .counter_cs_b(cs), .counter_reg(creg),
      .counter_rd_b(crd), .counter_wr_b(cwr),
      .upper_port_read_strobe_b(rs), .upper_port_write_strobe_b(ws),
      .card_sel(sel));
   // compare and count
   task check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   // verdict
   task close_out();
      if (err_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // reference decode of each settled cycle; reset idles the upper strobes
   always @(negedge clk) begin
      hit = int'(addr >> 3) == row * 4 + col && ctl < 4'h3;
      up = hit && addr[2] && rst_b;
      check("sel", sel, hit);
      check("oe", oe, hit && !ctl[1]);
      check("cnt", cs, !(hit && !addr[2]));
      check("reg", {creg, crd, cwr}, {addr[1:0], ctl[1:0]});
      check("rds", rs, 15 ^ (int'(up && !ctl[1]) << addr[1:0]));
      check("wrs", ws, 15 ^ (int'(up && !ctl[0]) << addr[1:0]));
      check("dat", {dout, wdat}, {rdat, din});
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 48; i++)
         u_cpu.cycle(8'hd0 + 8'(i / 2), i % 2 ? 4'h2 : 4'h1, 8'(i));
      foreach (bad[k])
         u_cpu.cycle(8'hdd, bad[k], 8'h5a);
      rst_b <= 1'b0;
      u_cpu.cycle(8'hdc, 4'h1, 8'h00);
      u_cpu.cycle(8'hdf, 4'h2, 8'h3c);
      rst_b <= 1'b1;
      repeat (400) begin
         row <= 3'($random(seed));
         col <= 2'($random(seed));
         rdat <= 8'($random(seed));
         @(posedge clk);
         u_cpu.cycle({row, col, 3'($random(seed))} ^ 8'($random(seed) & 128),
            4'($random(seed)) & 4'h3, 8'($random(seed)));
      end
      close_out();
   end
   // watchdog
   initial begin
      #200000;
      err_count++;
      close_out();
   end
endmodule : test_iopad_decoder
